//--- core/discrete_event_packetizer.sv
// discrete input packet body framer: channel word, stamps and states
//
// Summary of operation
// [RULE_01] each event carries one to 32 discrete input states
// [RULE_02] body order: channel word, then stamp and states per event
// [RULE_03] channel word bits 31 to 8 carry no function
// [RULE_04] bits 7 to 3 give bits per event, zero meaning 32
// [RULE_05] bit 0 low records on change, high records on interval
// [RULE_06] bit 1 gives lsb or msb alignment, bit 2 reserved
// [RULE_07] an event is the input states plus the time they were taken
// [RULE_08] state word bit n is the level of discrete input n
// [RULE_09] each event is preceded by a header holding only a stamp
// [RULE_10] header is eight bytes, low time word then high time word
// [RULE_11] relative time is 48 bits with top 16 bits zero
// [RULE_12] packet flag bit 6 selects absolute time in flagged format
// [RULE_13] stamp matches the moment the event states were captured
// [RULE_14] fields leave as 16-bit units, lowest bits first
// [RULE_15] all reserved channel word bits are written as zero
// [RULE_16] interval sampling period comes from a configuration input
`timescale 1ns/1ps
`default_nettype none
module discrete_event_packetizer
  import discrete_event_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        enable,
  input  wire logic        packet_start,
  input  wire logic        interval_mode,
  input  wire logic        msb_aligned,
  input  wire logic [4:0]  event_length,
  input  wire logic [31:0] interval_cycles,
  input  wire logic [7:0]  packet_flags,
  input  wire logic [47:0] relative_time,
  input  wire logic [63:0] absolute_time,
  input  wire logic [31:0] discrete_inputs,
  output logic             unit_valid,
  output logic [15:0]      unit_data,
  output logic             event_dropped,
  output logic             busy
);
  ////////////////////////////////////////////////////////////////////////
  // synchronisers, framer registers and decoded control
  logic          rst_meta_q;
  logic          rst_n_q;
  logic [31:0]   in_meta_q;
  logic [31:0]   in_sync_q;
  framer_state_e state_q;
  logic [2:0]    unit_q;
  logic [31:0]   chan_q;
  logic [31:0]   states_q;
  logic [63:0]   stamp_q;
  logic [31:0]   event_mask;
  logic [63:0]   time_now;
  logic [31:0]   chan_word;
  event_capture_if cap ();

  // mask of the low n bits, where n comes from the length field
  // a zero length field stands for a full event of 32 states
  function automatic logic [31:0] length_mask(input logic [4:0] len);
    logic [5:0] bits;
    bits = (len == length_zero) ? full_event_bits : {1'b0, len}; // [RULE_04]
    length_mask = (bits == full_event_bits) ? 32'hFFFF_FFFF :
                  ((32'h0000_0001 << bits) - count_one); // [RULE_01]
  endfunction

  // pick one 16-bit unit of a 32-bit word, low half first
  function automatic logic [15:0] half(input logic [31:0] w,
                                       input logic hi);
    half = hi ? w[31:16] : w[15:0]; // [RULE_14]
  endfunction

  // mirror the low mask when the event is msb aligned, so a short event
  // keeps inputs 31 downward instead of 0 upward
  function automatic logic [31:0] align_mask(input logic [4:0] len,
                                             input logic       msb);
    logic [31:0] low;
    align_mask = 32'h0000_0000;
    low        = length_mask(len);
    for (int i = 0; i < input_count; i++) begin
      align_mask[i] = msb ? low[input_count - 1 - i] : low[i]; // [RULE_06]
    end
  endfunction

  // a slot is free on the last unit of an event or while waiting for one;
  // only there may a new event be loaded or the body be closed
  function automatic logic slot_free(input logic [2:0] idx);
    slot_free = (idx == unit_index_last) || (idx == unit_index_idle);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // reset release through two flops keeps the deassertion clean
  // the reset itself acts at once; only its release is timed
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // pins are asynchronous, so two flops before anything looks at them
  // a pin moving during sampling costs at most one extra event
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      in_meta_q <= 32'h0000_0000;
      in_sync_q <= 32'h0000_0000;
    end else begin
      in_meta_q <= discrete_inputs;
      in_sync_q <= in_meta_q; // [RULE_08]
    end
  end

  // msb alignment keeps the top n inputs, lsb alignment the bottom n;
  // change detection and the state word both see only those inputs
  assign event_mask = align_mask(event_length, msb_aligned);

  // relative time is zero filled above bit 47 unless absolute selected
  assign time_now = packet_flags[flag_abs_time] ? absolute_time : // [RULE_12]
                    {high_time_zero, relative_time}; // [RULE_11]

  // reserved fields forced to zero
  assign chan_word = {24'h00_0000, event_length, 1'b0, // [RULE_03] [RULE_15]
                      msb_aligned, interval_mode}; // [RULE_06]

  // the sampler runs while enable is high and the framer is out of st_idle, so an event can
  // already be taken while the channel word is still being sent
  discrete_event_sampler sampler (
    .clock           (clock),
    .rst_n           (rst_n_q),
    .enable          (enable && state_q != st_idle),
    .interval_mode   (interval_mode),
    .interval_cycles (interval_cycles),
    .inputs_sync     (in_sync_q),
    .event_mask      (event_mask),
    .time_now        (time_now),
    .cap             (cap)
  );

  ////////////////////////////////////////////////////////////////////////
  // framer state; an event arriving while the previous one is still
  // leaving is dropped and flagged, since there is no buffer
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q       <= st_idle;
      unit_q        <= unit_index_zero;
      chan_q        <= channel_word_rst;
      states_q      <= 32'h0000_0000;
      stamp_q       <= 64'h0000_0000_0000_0000;
      event_dropped <= 1'b0;
    end else begin
      event_dropped <= 1'b0;
      case (state_q)
        st_idle: begin
          // the channel word is latched so it matches the body that follows
          if (packet_start && enable) begin
            state_q <= st_channel; // [RULE_02]
            chan_q  <= chan_word;
            unit_q  <= unit_index_zero;
          end
        end
        st_channel: begin
          // two units, low half then high half
          if (unit_q == unit_index_chan) begin
            state_q <= st_event;
            unit_q  <= unit_index_idle;
          end else begin
            unit_q <= unit_q + 3'h1;
          end
        end
        st_event: begin
          // a stop waits for a free slot so no event leaves cut short
          if (!enable && slot_free(unit_q)) begin
            state_q <= st_idle;
          end else if (cap.strobe) begin
            if (slot_free(unit_q)) begin
              stamp_q  <= cap.stamp;
              states_q <= cap.states;
              unit_q   <= unit_index_zero; // [RULE_09]
            end else begin
              event_dropped <= 1'b1;
              unit_q        <= unit_q + 3'h1;
            end
          end else if (unit_q != unit_index_idle) begin
            unit_q <= (unit_q == unit_index_last) ? unit_index_idle :
                      unit_q + 3'h1;
          end
        end
        default: state_q <= st_idle;
      endcase
    end
  end

  // output units: stamp low to high, then states low to high
  // unit_valid pulses once per unit; the writer cannot stall, so every
  // unit it misses is lost
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      unit_valid <= 1'b0;
      unit_data  <= 16'h0000;
      busy       <= 1'b0;
    end else begin
      busy       <= (state_q != st_idle);
      unit_valid <= 1'b0;
      if (state_q == st_channel) begin
        unit_valid <= 1'b1;
        unit_data  <= half(chan_q, unit_q[0]); // [RULE_14]
      end else if (state_q == st_event && unit_q <= unit_index_last) begin
        unit_valid <= 1'b1;
        case (unit_q)
          3'h0: unit_data <= half(stamp_q[31:0], 1'b0); // [RULE_10]
          3'h1: unit_data <= half(stamp_q[31:0], 1'b1);
          3'h2: unit_data <= half(stamp_q[63:32], 1'b0);
          3'h3: unit_data <= half(stamp_q[63:32], 1'b1);
          3'h4: unit_data <= half(states_q, 1'b0);
          3'h5: unit_data <= half(states_q, 1'b1);
          default: unit_data <= 16'h0000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

//--- core/discrete_event_pkg.sv
// constants and types shared by the discrete event packetizer
package discrete_event_pkg;
  localparam int unsigned clock_period_ns  = 10;
  localparam int unsigned input_count      = 32;
  localparam int unsigned unit_width       = 16;
  localparam int unsigned time_width       = 64;
  localparam int unsigned rtc_width        = 48;
  // channel word field positions
  localparam int unsigned trigger_bit      = 0;
  localparam int unsigned align_bit        = 1;
  localparam int unsigned length_lsb       = 3;
  localparam int unsigned length_width     = 5;
  localparam logic [31:0] channel_word_rst = 32'h0000_0000;
  localparam logic [15:0] high_time_zero   = 16'h0000;
  localparam logic [31:0] interval_default = 32'h0000_0064;
  localparam logic [2:0]  unit_index_last  = 3'h5;
  localparam logic [2:0]  unit_index_zero  = 3'h0;
  localparam logic [2:0]  unit_index_chan  = 3'h1;
  localparam logic [2:0]  unit_index_idle  = 3'h7;
  localparam logic [31:0] count_one        = 32'h0000_0001;
  localparam logic [5:0]  full_event_bits  = 6'h20;
  localparam logic [4:0]  length_zero      = 5'h00;
  // packet flag bit that switches the stamp to absolute time
  localparam int unsigned flag_abs_time    = 6;
  localparam int unsigned flag_fmt_lsb     = 2;

  typedef enum logic [1:0] {
    st_idle    = 2'b00,
    st_channel = 2'b01,
    st_event   = 2'b10
  } framer_state_e;
endpackage

//--- core/discrete_event_sampler.sv
// samples the synchronised inputs and decides when an event is taken
`timescale 1ns/1ps
`default_nettype none
module discrete_event_sampler
  import discrete_event_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        enable,
  input  wire logic        interval_mode,
  input  wire logic [31:0] interval_cycles,
  input  wire logic [31:0] inputs_sync,
  input  wire logic [31:0] event_mask,
  input  wire logic [63:0] time_now,
  event_capture_if.sampler cap
);
  logic [31:0] last_q;
  logic [31:0] tick_q;
  logic        fire;

  // change mode compares only bits inside the event length
  assign fire = enable && (interval_mode ?
                (tick_q + count_one >= interval_cycles) :
                (((inputs_sync ^ last_q) & event_mask) != 32'h0000_0000));

  // interval counter restarts each time a sample is due
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tick_q <= 32'h0000_0000;
    end else if (!enable || !interval_mode || fire) begin
      tick_q <= 32'h0000_0000; // [RULE_16]
    end else begin
      tick_q <= tick_q + count_one;
    end
  end

  // the stamp is caught in the same edge as the states
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      last_q     <= 32'h0000_0000;
      cap.strobe <= 1'b0;
      cap.states <= 32'h0000_0000;
      cap.stamp  <= 64'h0000_0000_0000_0000;
    end else begin
      cap.strobe <= fire; // [RULE_05]
      if (fire) begin
        last_q     <= inputs_sync;
        cap.states <= inputs_sync & event_mask; // [RULE_07]
        cap.stamp  <= time_now; // [RULE_13]
      end
    end
  end
endmodule
`default_nettype wire

//--- core/event_capture_if.sv
// capture strobe and sampled event carried from sampler to framer
`timescale 1ns/1ps
`default_nettype none
interface event_capture_if;
  logic        strobe;
  logic [31:0] states;
  logic [63:0] stamp;
  modport sampler (output strobe, output states, output stamp);
  modport framer  (input  strobe, input  states, input  stamp);
endinterface
`default_nettype wire

//--- tb/discrete_event_monitor.sv
// assertion checker on the packetizer top ports
`timescale 1ns/1ps
`default_nettype none
module discrete_event_monitor (
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        enable,
  input wire logic        packet_start,
  input wire logic        interval_mode,
  input wire logic        msb_aligned,
  input wire logic [4:0]  event_length,
  input wire logic [7:0]  packet_flags,
  input wire logic        unit_valid,
  input wire logic [15:0] unit_data,
  input wire logic        event_dropped,
  input wire logic        busy
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  a_start_answer: assert property (
    packet_start && enable && !busy && !unit_valid |->
    ##2 unit_valid ##1 unit_valid)
    else $error("channel word did not follow start");
  a_channel_low: assert property (
    packet_start && enable && !busy && !unit_valid |->
    ##2 unit_data == {8'h00, event_length, 1'b0, msb_aligned,
                      interval_mode})
    else $error("channel word low half wrong");
  a_channel_high: assert property (
    packet_start && enable && !busy && !unit_valid |->
    ##3 unit_data == 16'h0000)
    else $error("channel word high half not zero");
  a_event_six: assert property (
    $rose(unit_valid) && $past(busy, 2) |-> unit_valid[*6])
    else $error("event not six back to back units");
  a_high_zero: assert property (
    $rose(unit_valid) && $past(busy, 2) && !packet_flags[6] |->
    ##3 unit_data == 16'h0000)
    else $error("relative stamp top bits not zero");
  a_units_busy: assert property (unit_valid |-> busy)
    else $error("unit sent while idle");
  a_reset_quiet: assert property (
    $rose(resetn) |-> (!unit_valid)[*3])
    else $error("unit during reset release");
  a_drop_window: assert property (
    event_dropped |-> unit_valid || $past(unit_valid))
    else $error("drop flagged outside an event");
endmodule
bind discrete_event_packetizer discrete_event_monitor mon (.clock(clock),
  .resetn(resetn), .enable(enable), .packet_start(packet_start),
  .interval_mode(interval_mode), .msb_aligned(msb_aligned),
  .event_length(event_length), .packet_flags(packet_flags),
  .unit_valid(unit_valid), .unit_data(unit_data),
  .event_dropped(event_dropped), .busy(busy));
`default_nettype wire

//--- tb/discrete_event_packetizer_bench.sv
// self-checking bench for the discrete event packetizer
`timescale 1ns/1ps
`default_nettype none
module discrete_event_packetizer_bench;
  logic        clock = 1'b0, resetn = 1'b0, enable = 1'b0, start = 1'b0;
  logic        im = 1'b0, ma = 1'b0, unit_valid, event_dropped, busy;
  logic        drop_seen = 1'b0;
  logic [4:0]  len = 5'h00;
  logic [31:0] period = 32'h0000_0014, pins = 32'h0000_0000;
  logic [7:0]  flags = 8'h00;
  logic [47:0] rel = 48'h1234_5678_9abc;
  logic [63:0] abs_t = 64'hfedc_ba98_7654_3210;
  logic [15:0] unit_data;
  int          n_errors = 0, comparisons = 0, n_units, base, gap;
  always #5 clock = ~clock;
  always @(posedge clock) if (event_dropped === 1'b1) drop_seen <= 1'b1;
  discrete_event_packetizer dut (.clock(clock), .resetn(resetn),
    .enable(enable), .packet_start(start), .interval_mode(im),
    .msb_aligned(ma), .event_length(len), .interval_cycles(period),
    .packet_flags(flags), .relative_time(rel), .absolute_time(abs_t),
    .discrete_inputs(pins), .unit_valid(unit_valid), .unit_data(unit_data),
    .event_dropped(event_dropped), .busy(busy));
  unit_sink sink (.clock(clock), .unit_valid(unit_valid),
    .unit_data(unit_data), .n_units(n_units));
  task automatic tally_and_finish();
    if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmp16(input string what, input logic [15:0] e,
                       input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  // bounded wait for the sink to hold n units
  task automatic wait_units(input int n);
    for (int i = 0; i < 300 && n_units < n; i++) @(negedge clock);
    if (n_units < n) begin
      n_errors++;
      tally_and_finish();
    end
  endtask
  task automatic open_pkt(input logic i, input logic m, input logic [4:0] l);
    @(negedge clock);
    im = i;
    ma = m;
    len = l;
    enable = 1'b1;
    start = 1'b1;
    base = n_units;
    @(negedge clock);
    start = 1'b0;
    wait_units(base + 2);
    cmp16("chan_lo", {8'h00, l, 1'b0, m, i}, sink.units[base]);
    cmp16("chan_hi", 16'h0000, sink.units[base + 1]);
  endtask
  // idle is reached at the next event slot once enable drops
  task automatic close_pkt();
    @(negedge clock);
    enable = 1'b0;
    for (int i = 0; i < 100 && busy !== 1'b0; i++) @(negedge clock);
    cmp16("idle", 16'h0000, {15'h0000, busy});
    if (busy !== 1'b0) tally_and_finish();
  endtask
  // e is the state word expected after masking by length and alignment
  task automatic fire(input logic [31:0] v, input logic [31:0] e,
                      input logic [63:0] st);
    @(negedge clock);
    base = n_units;
    pins = v;
    wait_units(base + 6);
    for (int k = 0; k < 4; k++)
      cmp16("stamp", st[16*k +: 16], sink.units[base + k]);
    cmp16("state_lo", e[15:0], sink.units[base + 4]);
    cmp16("state_hi", e[31:16], sink.units[base + 5]);
  endtask
  initial begin
    repeat (8) @(negedge clock);
    resetn = 1'b1;
    repeat (4) @(negedge clock);
    // a short msb aligned event keeps only the top eight inputs
    open_pkt(1'b0, 1'b1, 5'h08);
    fire(32'hff00_00ff, 32'hff00_0000, {16'h0000, rel});
    close_pkt();
    open_pkt(1'b0, 1'b0, 5'h00);
    fire(32'ha5c3_0f0f, 32'ha5c3_0f0f, {16'h0000, rel});
    flags = 8'h40;
    fire(32'h5a3c_f0f0, 32'h5a3c_f0f0, abs_t);
    // a second change lands while the first event's third unit leaves
    base = n_units;
    pins = 32'h0000_0001;
    repeat (3) @(negedge clock);
    pins = 32'h0000_0003;
    repeat (30) @(negedge clock);
    cmp16("dropped", 16'h0001, {15'h0000, drop_seen});
    cmp16("units", 16'h0006, 16'(n_units - base));
    cmp16("kept", 16'h0001, sink.units[base + 4]);
    close_pkt();
    flags = 8'h00;
    open_pkt(1'b1, 1'b0, 5'h00);
    wait_units(n_units + 6);
    base = n_units;
    gap = 0;
    while (n_units < base + 6 && gap < 100) begin
      @(negedge clock);
      gap++;
    end
    cmp16("period", period[15:0], 16'(gap));
    if (gap >= 100) tally_and_finish();
    close_pkt();
    tally_and_finish();
  end
endmodule
`default_nettype wire

//--- tb/unit_sink.sv
// stream writer model: stores every unit the packetizer emits
`timescale 1ns/1ps
`default_nettype none
module unit_sink (
  input  wire logic        clock,
  input  wire logic        unit_valid,
  input  wire logic [15:0] unit_data,
  output var int           n_units
);
  logic [15:0] units [0:255];
  initial n_units = 0;
  // the writer has no stall, so every valid unit is taken
  always @(posedge clock) begin
    if (unit_valid === 1'b1) begin
      units[n_units] <= unit_data;
      n_units <= n_units + 1;
    end
  end
endmodule
`default_nettype wire
